// [bit_core_end.sv]
// core end: executes branch, compare-branch, prefix, breakpoint and
// exception-return instructions and keeps the conditional block state
// assumes the stream holds each request stable until taken
`timescale 1ns/10ps
module bit_core_end (
   input wire logic I_CLOCK, // core clock
   input wire logic I_SRST, // synchronous reset, high
   input wire logic I_CKE, // clock enable
   input wire logic [3:0] I_FLAGS, // flags from the arithmetic unit
   input wire logic I_FLAGS_WE, // arithmetic unit writes flags
   input wire logic I_EXC_REQ, // pending exception
   output logic [3:0] O_FLAGS, // current flags {n,z,c,v}
   output logic O_LINK_WE, // link register write pulse
   output logic [31:0] O_LINK_VAL, // link register value
   output logic O_EXC_ENTRY, // exception entered pulse
   output logic [31:0] O_STACKED_PSR, // stacked status word
   output logic O_IN_HANDLER, // executing an exception handler
   output logic O_DEBUG_HALT, // breakpoint executed pulse
   output logic O_USAGE_FAULT, // usage fault pulse
   bit_link_if.core lk // from the stream
);
   bit_pkg::bit_state_e state;
   bit_pkg::bit_state_e next_state;
   logic [3:0] flags;
   logic [3:0] next_flags;
   logic [3:0] it_base;
   logic [3:0] next_it_base;
   logic it_else;
   logic next_it_else;
   logic [2:0] it_sw;
   logic [2:0] next_it_sw;
   logic [2:0] it_left;
   logic [2:0] next_it_left;
   logic [31:0] resume_pc;
   logic [31:0] next_resume_pc;
   logic ready;
   logic next_done;
   logic next_taken;
   logic [31:0] next_target;
   logic next_skipped;
   logic next_range;
   logic next_link_we;
   logic [31:0] next_link_val;
   logic next_entry;
   logic [31:0] next_psr;
   logic next_halt;
   logic next_fault;
   logic accept;
   logic in_it;
   logic [3:0] slot_cond;
   logic pass;
   logic [31:0] seq;
   logic [31:0] dest;
   logic short_ok;
   logic long_ok;
   logic [bit_pkg::IT_STATE_W-1:0] it_word;

   always_comb begin
      accept = lk.req_valid && ready;
      in_it = (it_left != 3'h0);
      slot_cond = it_else ? (it_base ^ 4'h1) : it_base;
      pass = in_it ? bit_pkg::cond_ok(slot_cond, flags) :
             (lk.op == bit_pkg::OP_B) ? bit_pkg::cond_ok(lk.cond, flags) : 1'b1;
      seq = lk.pc + (lk.wide ? bit_pkg::WIDE_LEN : bit_pkg::NARROW_LEN);
      dest = lk.pc + lk.imm;
      short_ok = (lk.imm[31:bit_pkg::SHORT_REACH_MSB] == {12{lk.imm[31]}});
      long_ok = (lk.imm[31:bit_pkg::LONG_REACH_MSB] == {8{lk.imm[31]}});
      it_word = {it_base, it_else, it_sw, it_left};
      next_state = state;
      next_flags = I_FLAGS_WE ? I_FLAGS : flags;
      next_it_base = it_base;
      next_it_else = it_else;
      next_it_sw = it_sw;
      next_it_left = it_left;
      next_resume_pc = resume_pc;
      next_done = 1'b0;
      next_taken = 1'b0;
      next_target = lk.rsp_target;
      next_skipped = 1'b0;
      next_range = 1'b0;
      next_link_we = 1'b0;
      next_link_val = O_LINK_VAL;
      next_entry = 1'b0;
      next_psr = O_STACKED_PSR;
      next_halt = 1'b0;
      next_fault = 1'b0;
      if (accept) begin
         next_done = 1'b1;
         next_target = seq;
         if (in_it) begin
            next_it_left = it_left - 3'h1;
            next_it_else = it_sw[0];
            next_it_sw = {1'b0, it_sw[2:1]};
         end
         if (lk.op == bit_pkg::OP_BREAKPOINT_INSTR) begin
            next_halt = 1'b1;
         end else if (!pass) begin
            next_skipped = 1'b1;
         end else begin
            case (lk.op)
               bit_pkg::OP_B, bit_pkg::OP_BL: begin
                  if ((in_it || lk.op == bit_pkg::OP_BL ||
                       lk.cond == bit_pkg::EVERY_TIME_CODE) ? long_ok : short_ok) begin
                     next_taken = 1'b1;
                     next_target = dest;
                     next_link_we = (lk.op == bit_pkg::OP_BL);
                     next_link_val = (lk.op == bit_pkg::OP_BL) ? seq : O_LINK_VAL;
                  end else begin
                     next_range = 1'b1;
                  end
               end
               bit_pkg::OP_BX, bit_pkg::OP_BLX: begin
                  if (!lk.rval[0]) begin
                     next_fault = 1'b1;
                  end else begin
                     next_taken = 1'b1;
                     next_target = {lk.rval[31:1], 1'b0};
                     next_link_we = (lk.op == bit_pkg::OP_BLX);
                     next_link_val = (lk.op == bit_pkg::OP_BLX) ? seq : O_LINK_VAL;
                  end
               end
               bit_pkg::OP_CBZ, bit_pkg::OP_COMPARE_NONZERO_BRANCH: begin
                  if (lk.imm < bit_pkg::CMP_BR_MIN || lk.imm > bit_pkg::CMP_BR_MAX) begin
                     next_range = 1'b1;
                  end else if ((lk.rval == bit_pkg::RESET_WORD) == (lk.op == bit_pkg::OP_CBZ)) begin
                     next_taken = 1'b1;
                     next_target = dest;
                  end
               end
               bit_pkg::OP_IT: begin
                  next_it_base = lk.cond;
                  next_it_else = 1'b0;
                  next_it_sw = lk.imm[bit_pkg::IT_SW_LSB +: 3];
                  next_it_left = {1'b0, lk.imm[bit_pkg::IT_CNT_LSB +: 2]} + 3'h1;
               end
               bit_pkg::OP_ERET: begin
                  if (state == bit_pkg::ST_HANDLER) begin
                     {next_it_base, next_it_else, next_it_sw, next_it_left} =
                        lk.imm[bit_pkg::IT_STATE_W-1:0];
                     next_state = bit_pkg::ST_RUN;
                     next_taken = 1'b1;
                     next_target = lk.rval;
                  end
               end
               default: begin
                  next_taken = 1'b0;
               end
            endcase
         end
         next_resume_pc = next_taken ? next_target : seq;
      end else if (I_EXC_REQ && state == bit_pkg::ST_RUN) begin
         next_entry = 1'b1;
         next_link_we = 1'b1;
         next_link_val = resume_pc;
         next_psr = {flags, {(bit_pkg::PSR_FLAGS_LSB - bit_pkg::IT_STATE_W){1'b0}}, it_word};
         next_state = bit_pkg::ST_HANDLER;
         next_it_base = 4'h0;
         next_it_else = 1'b0;
         next_it_sw = 3'h0;
         next_it_left = 3'h0;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         state <= bit_pkg::ST_RUN;
         flags <= bit_pkg::RESET_FLAGS;
         it_base <= 4'h0;
         it_else <= 1'b0;
         it_sw <= 3'h0;
         it_left <= 3'h0;
         resume_pc <= bit_pkg::RESET_WORD;
         ready <= 1'b0;
         lk.rsp_done <= 1'b0;
         lk.rsp_taken <= 1'b0;
         lk.rsp_target <= bit_pkg::RESET_WORD;
         lk.rsp_skipped <= 1'b0;
         lk.rsp_range_err <= 1'b0;
         lk.it_left <= 3'h0;
         lk.it_cond <= 4'h0;
         O_FLAGS <= bit_pkg::RESET_FLAGS;
         O_LINK_WE <= 1'b0;
         O_LINK_VAL <= bit_pkg::RESET_WORD;
         O_EXC_ENTRY <= 1'b0;
         O_STACKED_PSR <= bit_pkg::RESET_WORD;
         O_IN_HANDLER <= 1'b0;
         O_DEBUG_HALT <= 1'b0;
         O_USAGE_FAULT <= 1'b0;
      end else if (I_CKE) begin
         state <= next_state;
         flags <= next_flags;
         it_base <= next_it_base;
         it_else <= next_it_else;
         it_sw <= next_it_sw;
         it_left <= next_it_left;
         resume_pc <= next_resume_pc;
         ready <= 1'b1;
         lk.rsp_done <= next_done;
         lk.rsp_taken <= next_taken;
         lk.rsp_target <= next_target;
         lk.rsp_skipped <= next_skipped;
         lk.rsp_range_err <= next_range;
         lk.it_left <= next_it_left;
         lk.it_cond <= next_it_else ? (next_it_base ^ 4'h1) : next_it_base;
         O_FLAGS <= next_flags;
         O_LINK_WE <= next_link_we;
         O_LINK_VAL <= next_link_val;
         O_EXC_ENTRY <= next_entry;
         O_STACKED_PSR <= next_psr;
         O_IN_HANDLER <= (next_state == bit_pkg::ST_HANDLER);
         O_DEBUG_HALT <= next_halt;
         O_USAGE_FAULT <= next_fault;
      end
   end

   assign lk.req_ready = ready;
endmodule

// [bit_pkg.sv]
// constants, types and condition test shared by the core end and the stream end
// assumes a single core clock; instructions arrive already split into fields
package bit_pkg;
   typedef enum logic [3:0] {
      OP_OTHER = 4'h0,
      OP_B = 4'h1,
      OP_BL = 4'h2,
      OP_BX = 4'h3,
      OP_BLX = 4'h4,
      OP_CBZ = 4'h5,
      OP_COMPARE_NONZERO_BRANCH = 4'h6,
      OP_IT = 4'h7,
      OP_BREAKPOINT_INSTR = 4'h8,
      OP_ERET = 4'h9
   } bit_op_e;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_HANDLER = 2'b10
   } bit_state_e;

   localparam logic [3:0] EVERY_TIME_CODE = 4'he;
   localparam logic [3:0] PC_REG_NUM = 4'hf;
   localparam logic [3:0] LOW_REG_MAX = 4'h7;
   localparam logic [31:0] NARROW_LEN = 32'h2;
   localparam logic [31:0] WIDE_LEN = 32'h4;
   localparam logic [31:0] CMP_BR_MIN = 32'h4;
   localparam logic [31:0] CMP_BR_MAX = 32'h82;
   // reach checks: offset must sign-extend from this bit
   localparam int SHORT_REACH_MSB = 20;
   localparam int LONG_REACH_MSB = 24;
   // prefix immediate: else switches for slots 2..4, then count minus one
   localparam int IT_SW_LSB = 0;
   localparam int IT_CNT_LSB = 4;
   // stacked status word layout
   localparam int PSR_FLAGS_LSB = 28;
   localparam int IT_STATE_W = 11;
   localparam logic [31:0] RESET_WORD = 32'h0;
   localparam logic [3:0] RESET_FLAGS = 4'h0;

   // flags are {n,z,c,v}
   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
      logic r;
      r = 1'b1;
      case (c[3:1])
         3'h0: r = f[2];
         3'h1: r = f[1];
         3'h2: r = f[3];
         3'h3: r = f[0];
         3'h4: r = f[1] & ~f[2];
         3'h5: r = (f[3] == f[0]);
         3'h6: r = ~f[2] & (f[3] == f[0]);
         default: r = 1'b1;
      endcase
      if (c[0] && c != 4'hf) begin
         r = ~r;
      end
      return r;
   endfunction
endpackage

// [bit_link_if.sv]
// instruction hand-over between the stream end and the core end
// assumes both ends share the core clock; requests use valid/ready
`timescale 1ns/10ps
interface bit_link_if;
   logic req_valid;
   bit_pkg::bit_op_e op;
   logic [3:0] cond;
   logic [3:0] rnum;
   logic [31:0] rval;
   logic [31:0] imm;
   logic [31:0] pc;
   logic wide;
   logic req_ready;
   logic rsp_done;
   logic rsp_taken;
   logic [31:0] rsp_target;
   logic rsp_skipped;
   logic rsp_range_err;
   logic [2:0] it_left;
   logic [3:0] it_cond;

   modport core (
      input req_valid, op, cond, rnum, rval, imm, pc, wide,
      output req_ready, rsp_done, rsp_taken, rsp_target, rsp_skipped, rsp_range_err,
      output it_left, it_cond
   );
   modport stream (
      output req_valid, op, cond, rnum, rval, imm, pc, wide,
      input req_ready, rsp_done, rsp_taken, rsp_target, rsp_skipped, rsp_range_err,
      input it_left, it_cond
   );
endinterface

// [bit_stream_end.sv]
// instruction stream end: takes one instruction at a time from its user and
// forwards it to the core, dropping any that break placement, register or prefix-encoding restrictions
`timescale 1ns/10ps
module bit_stream_end (
   input wire logic I_CLOCK, // core clock
   input wire logic I_SRST, // synchronous reset, high
   input wire logic I_CKE, // clock enable
   input wire logic I_VALID, // instruction offered
   input wire bit_pkg::bit_op_e I_OP, // instruction class
   input wire logic [3:0] I_COND, // condition code
   input wire logic [3:0] I_RNUM, // operand register number
   input wire logic [31:0] I_RVAL, // operand register value
   input wire logic [31:0] I_IMM, // offset or prefix fields
   input wire logic [31:0] I_PC, // instruction address
   input wire logic I_WIDE, // four-byte instruction
   output logic O_READY, // instruction taken when high with valid
   output logic O_DONE, // core finished one instruction
   output logic O_TAKEN, // that instruction branched
   output logic [31:0] O_TARGET, // next address
   output logic O_VIOLATION, // offered instruction dropped
   bit_link_if.stream lk // to the core
);
   logic pend;
   logic next_pend;
   logic next_ready;
   logic next_done;
   logic next_taken;
   logic [31:0] next_target;
   logic next_viol;
   logic bad;
   logic in_it;
   logic last_slot;

   always_comb begin
      in_it = (lk.it_left != 3'h0);
      last_slot = (lk.it_left == 3'h1);
      bad = 1'b0;
      if (I_OP == bit_pkg::OP_BLX && I_RNUM == bit_pkg::PC_REG_NUM) begin
         bad = 1'b1;
      end
      if (in_it && !last_slot && (I_OP == bit_pkg::OP_BL || I_OP == bit_pkg::OP_BX ||
          I_OP == bit_pkg::OP_BLX || I_OP == bit_pkg::OP_ERET ||
          (I_OP == bit_pkg::OP_B && I_COND == bit_pkg::EVERY_TIME_CODE))) begin
         bad = 1'b1;
      end
      if ((I_OP == bit_pkg::OP_CBZ || I_OP == bit_pkg::OP_COMPARE_NONZERO_BRANCH) &&
          I_RNUM > bit_pkg::LOW_REG_MAX) begin
         bad = 1'b1;
      end
      if (in_it && (I_OP == bit_pkg::OP_CBZ || I_OP == bit_pkg::OP_COMPARE_NONZERO_BRANCH ||
          I_OP == bit_pkg::OP_IT)) begin
         bad = 1'b1;
      end
      if (I_OP == bit_pkg::OP_IT && I_COND == bit_pkg::EVERY_TIME_CODE &&
          I_IMM[bit_pkg::IT_SW_LSB +: 3] != 3'h0) begin
         bad = 1'b1;
      end
      if (in_it && I_OP != bit_pkg::OP_BREAKPOINT_INSTR && I_COND != lk.it_cond) begin
         bad = 1'b1;
      end
      next_pend = pend;
      next_viol = 1'b0;
      if (pend && lk.req_ready) begin
         next_pend = 1'b0;
      end
      if (O_READY && I_VALID) begin
         next_pend = !bad;
         next_viol = bad;
      end
      next_ready = !next_pend && !(O_READY && I_VALID);
      next_done = lk.rsp_done;
      next_taken = lk.rsp_done && lk.rsp_taken;
      next_target = lk.rsp_done ? lk.rsp_target : O_TARGET;
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         pend <= 1'b0;
         O_READY <= 1'b0;
         O_DONE <= 1'b0;
         O_TAKEN <= 1'b0;
         O_TARGET <= bit_pkg::RESET_WORD;
         O_VIOLATION <= 1'b0;
         lk.op <= bit_pkg::OP_OTHER;
         lk.cond <= bit_pkg::EVERY_TIME_CODE;
         lk.rnum <= 4'h0;
         lk.rval <= bit_pkg::RESET_WORD;
         lk.imm <= bit_pkg::RESET_WORD;
         lk.pc <= bit_pkg::RESET_WORD;
         lk.wide <= 1'b0;
      end else if (I_CKE) begin
         pend <= next_pend;
         O_READY <= next_ready;
         O_DONE <= next_done;
         O_TAKEN <= next_taken;
         O_TARGET <= next_target;
         O_VIOLATION <= next_viol;
         if (O_READY && I_VALID) begin
            lk.op <= I_OP;
            lk.cond <= I_COND;
            lk.rnum <= I_RNUM;
            lk.rval <= I_RVAL;
            lk.imm <= I_IMM;
            lk.pc <= I_PC;
            lk.wide <= I_WIDE;
         end
      end
   end

   assign lk.req_valid = pend;
endmodule

// [bit_chk_sva.sv]
// link checker for the branch and conditional block pair
// assumes one core clock; watches the link signals between the two ends
`timescale 1ns/10ps
module bit_chk (
   input wire logic I_CLOCK, // core clock
   input wire logic I_SRST, // synchronous reset, high
   input wire logic I_CKE, // clock enable
   input wire logic req_valid, // request pending
   input wire bit_pkg::bit_op_e op, // instruction class
   input wire logic [3:0] cond, // condition code
   input wire logic [31:0] rval, // operand value
   input wire logic [31:0] imm, // offset or prefix fields
   input wire logic req_ready, // core ready
   input wire logic rsp_done, // instruction finished
   input wire logic rsp_taken, // branched
   input wire logic [31:0] rsp_target, // next address
   input wire logic rsp_skipped, // condition failed
   input wire logic rsp_range_err, // beyond reach
   input wire logic [2:0] it_left, // slots remaining
   input wire logic [3:0] it_cond // next slot condition
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);
   wire acc = req_valid & req_ready & I_CKE;
   wire plain = acc && it_left == 3'h0 && cond == bit_pkg::EVERY_TIME_CODE;
   wire cmp = acc && (op == bit_pkg::OP_CBZ || op == bit_pkg::OP_COMPARE_NONZERO_BRANCH);
   wire in_rng = imm >= bit_pkg::CMP_BR_MIN && imm <= bit_pkg::CMP_BR_MAX;
   wire short_ok = imm[31:20] == 12'h0 || imm[31:20] == 12'hfff;
   wire long_ok = imm[31:24] == 8'h0 || imm[31:24] == 8'hff;
   wire [2:0] cnt = {1'b0, imm[5:4]} + 3'h1;
   a_done_follows: assert property (acc |=> rsp_done)
      else $error("no completion after accept");
   a_bx_even_target: assert property (plain && op == bit_pkg::OP_BX && rval[0] |=>
      rsp_taken && rsp_target == ($past(rval) & 32'hffff_fffe)) else $error("odd target");
   a_bx_lsb_fault: assert property (plain && (op == bit_pkg::OP_BX || op == bit_pkg::OP_BLX) &&
      !rval[0] |=> !rsp_taken) else $error("branched on even register");
   a_cbz_on_zero: assert property (cmp && op == bit_pkg::OP_CBZ && in_rng |=>
      rsp_taken == ($past(rval) == 32'h0)) else $error("zero branch wrong");
   a_compare_nonzero_branch_on_nonzero: assert property (cmp && op == bit_pkg::OP_COMPARE_NONZERO_BRANCH && in_rng |=>
      rsp_taken == ($past(rval) != 32'h0)) else $error("nonzero branch wrong");
   a_cmp_reach_limit: assert property (cmp && !in_rng |=> rsp_range_err && !rsp_taken)
      else $error("compare branch beyond reach");
   a_prefix_load: assert property (acc && op == bit_pkg::OP_IT && it_left == 3'h0 |=>
      it_left == $past(cnt) && it_cond == $past(cond)) else $error("block not loaded");
   a_slot_step: assert property (acc && it_left != 3'h0 && op != bit_pkg::OP_ERET |=>
      it_left == $past(it_left) - 3'h1) else $error("slot count not stepped");
   a_breakpoint_instr_never_skipped: assert property (acc && op == bit_pkg::OP_BREAKPOINT_INSTR |=>
      rsp_done && !rsp_skipped) else $error("breakpoint skipped");
   a_block_long_reach: assert property (acc && op == bit_pkg::OP_B && it_left != 3'h0 &&
      long_ok |=> !rsp_range_err) else $error("block branch reach short");
   a_short_reach: assert property (acc && op == bit_pkg::OP_B && it_left == 3'h0 &&
      cond != bit_pkg::EVERY_TIME_CODE && !short_ok |=> (rsp_range_err || rsp_skipped) &&
      !rsp_taken)
      else $error("conditional branch reach long");
endmodule

// [bit_tb_top.sv]
// testbench for the stream end and core end joined by the link
// assumes a 10 MHz clock and a synchronous active-high reset
`timescale 1ns/10ps
module branch_and_if_then_execution_tb_top;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic valid = 1'b0;
   bit_pkg::bit_op_e op = bit_pkg::OP_OTHER;
   logic [3:0] cond = 4'he;
   logic [3:0] rnum = 4'h0;
   logic [31:0] rval = 32'h0;
   logic [31:0] imm = 32'h0;
   logic [31:0] pc = 32'h0;
   logic wide = 1'b0;
   logic [3:0] flags = 4'h0;
   logic flags_we = 1'b0;
   logic exc = 1'b0;
   logic ready, done, taken, viol, link_we, entry, in_hnd, halt, fault;
   logic [31:0] target, link_val, program_status_word;
   logic [3:0] cur_flags;
   logic s_link, s_halt, s_fault, s_skip, s_rerr, s_entry, r_viol, r_taken;
   logic [31:0] r_target;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;
   bit_link_if lk ();
   bit_stream_end bit_stream_end_i (.I_CLOCK(clock), .I_SRST(srst), .I_CKE(1'b1),
      .I_VALID(valid), .I_OP(op), .I_COND(cond), .I_RNUM(rnum), .I_RVAL(rval), .I_IMM(imm),
      .I_PC(pc), .I_WIDE(wide), .O_READY(ready), .O_DONE(done), .O_TAKEN(taken),
      .O_TARGET(target), .O_VIOLATION(viol), .lk(lk));
   bit_core_end bit_core_end_i (.I_CLOCK(clock), .I_SRST(srst), .I_CKE(1'b1), .I_FLAGS(flags),
      .I_FLAGS_WE(flags_we), .I_EXC_REQ(exc), .O_FLAGS(cur_flags), .O_LINK_WE(link_we),
      .O_LINK_VAL(link_val), .O_EXC_ENTRY(entry), .O_STACKED_PSR(program_status_word), .O_IN_HANDLER(in_hnd),
      .O_DEBUG_HALT(halt), .O_USAGE_FAULT(fault), .lk(lk));
   bit_chk bit_chk_i (.I_CLOCK(clock), .I_SRST(srst), .I_CKE(1'b1), .req_valid(lk.req_valid),
      .op(lk.op), .cond(lk.cond), .rval(lk.rval), .imm(lk.imm), .req_ready(lk.req_ready),
      .rsp_done(lk.rsp_done), .rsp_taken(lk.rsp_taken), .rsp_target(lk.rsp_target),
      .rsp_skipped(lk.rsp_skipped), .rsp_range_err(lk.rsp_range_err), .it_left(lk.it_left),
      .it_cond(lk.it_cond));
   always #50 clock = ~clock;
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         $display("CHECK FAILED run length expected %0d seen %0d", 2000, cycles);
         print_verdict();
      end
   end
   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      chk_word(what, {31'h0, e}, {31'h0, g});
   endtask
   // one edge; pulses of the previous cycle are gathered
   task automatic step();
      @(posedge clock);
      s_link |= link_we;
      s_halt |= halt;
      s_fault |= fault;
      s_skip |= lk.rsp_skipped;
      s_rerr |= lk.rsp_range_err;
      s_entry |= entry;
   endtask
   task automatic issue(input bit_pkg::bit_op_e o, input logic [3:0] c, input logic [3:0] rn,
         input logic [31:0] rv, input logic [31:0] im, input logic [31:0] p, input logic w);
      int n;
      {s_link, s_halt, s_fault, s_skip, s_rerr} = 5'h0;
      op <= o;
      cond <= c;
      rnum <= rn;
      rval <= rv;
      imm <= im;
      pc <= p;
      wide <= w;
      valid <= 1'b1;
      n = 0;
      do begin step(); n++; end while (ready !== 1'b1 && n < 20);
      valid <= 1'b0;
      n = 0;
      do begin step(); n++; end while (done !== 1'b1 && viol !== 1'b1 && n < 20);
      r_viol = viol;
      r_taken = taken;
      r_target = target;
   endtask
   task automatic t_branch();
      issue(bit_pkg::OP_B, 4'h0, 4'h0, 32'h0, 32'h100, 32'h1000, 1'b0);
      chk_word("cond branch target", 32'h1100, r_target);
      issue(bit_pkg::OP_BL, 4'he, 4'h0, 32'h0, 32'h40, 32'h2000, 1'b1);
      chk_bit("link write", 1'b1, s_link);
      chk_word("link value", 32'h2004, link_val);
      issue(bit_pkg::OP_BX, 4'he, 4'h1, 32'h3001, 32'h0, 32'h2100, 1'b0);
      chk_word("indirect target", 32'h3000, r_target);
      issue(bit_pkg::OP_BLX, 4'he, 4'h2, 32'h3000, 32'h0, 32'h2200, 1'b0);
      chk_bit("even register fault", 1'b1, s_fault);
      chk_bit("even register taken", 1'b0, r_taken);
      issue(bit_pkg::OP_B, 4'h0, 4'h0, 32'h0, 32'h0020_0000, 32'h2300, 1'b0);
      chk_bit("short reach error", 1'b1, s_rerr);
      issue(bit_pkg::OP_BLX, 4'he, 4'hf, 32'h3001, 32'h0, 32'h2400, 1'b0);
      chk_bit("call from pc dropped", 1'b1, r_viol);
      chk_word("flags kept", 32'h4, {28'h0, cur_flags});
      $display("test branch done");
   endtask
   task automatic t_cmp();
      issue(bit_pkg::OP_CBZ, 4'he, 4'h3, 32'h0, 32'h82, 32'h100, 1'b0);
      chk_word("zero branch far target", 32'h182, r_target);
      chk_bit("zero branch taken", 1'b1, r_taken);
      issue(bit_pkg::OP_CBZ, 4'he, 4'h3, 32'h5, 32'h4, 32'h100, 1'b0);
      chk_bit("zero branch falls", 1'b0, r_taken);
      issue(bit_pkg::OP_COMPARE_NONZERO_BRANCH, 4'he, 4'h7, 32'h5, 32'h4, 32'h100, 1'b0);
      chk_word("nonzero branch target", 32'h104, r_target);
      issue(bit_pkg::OP_COMPARE_NONZERO_BRANCH, 4'he, 4'h7, 32'h0, 32'h4, 32'h100, 1'b0);
      chk_bit("nonzero branch falls", 1'b0, r_taken);
      issue(bit_pkg::OP_CBZ, 4'he, 4'h0, 32'h0, 32'h84, 32'h100, 1'b0);
      chk_bit("compare reach error", 1'b1, s_rerr);
      issue(bit_pkg::OP_CBZ, 4'he, 4'h8, 32'h0, 32'h4, 32'h100, 1'b0);
      chk_bit("high register dropped", 1'b1, r_viol);
      issue(bit_pkg::OP_IT, 4'he, 4'h0, 32'h0, 32'h31, 32'h100, 1'b0);
      chk_bit("always prefix with else", 1'b1, r_viol);
      chk_word("flags kept", 32'h4, {28'h0, cur_flags});
      $display("test compare done");
   endtask
   task automatic t_block();
      issue(bit_pkg::OP_IT, 4'h0, 4'h0, 32'h0, 32'h32, 32'h400, 1'b0);
      issue(bit_pkg::OP_CBZ, 4'h0, 4'h1, 32'h0, 32'h4, 32'h402, 1'b0);
      chk_bit("compare in block dropped", 1'b1, r_viol);
      issue(bit_pkg::OP_OTHER, 4'h1, 4'h0, 32'h0, 32'h0, 32'h402, 1'b0);
      chk_bit("slot cond mismatch dropped", 1'b1, r_viol);
      issue(bit_pkg::OP_BX, 4'h0, 4'h1, 32'h3001, 32'h0, 32'h402, 1'b0);
      chk_bit("early branch dropped", 1'b1, r_viol);
      for (int i = 0; i < 3; i++) begin
         chk_word("slots left", 32'(4 - i), {29'h0, lk.it_left});
         chk_word("slot cond", {28'h0, (i == 2) ? 4'h1 : 4'h0}, {28'h0, lk.it_cond});
         issue(bit_pkg::OP_OTHER, (i == 2) ? 4'h1 : 4'h0, 4'h0, 32'h0, 32'h0,
            32'h402 + 32'(2 * i), 1'b0);
         chk_bit("slot skipped", i == 2, s_skip);
      end
      issue(bit_pkg::OP_B, 4'h0, 4'h0, 32'h0, 32'h0020_0000, 32'h408, 1'b0);
      chk_word("long reach target", 32'h0020_0408, r_target);
      chk_word("block cleared", 32'h0, {29'h0, lk.it_left});
      issue(bit_pkg::OP_IT, 4'h1, 4'h0, 32'h0, 32'h0, 32'h500, 1'b0);
      issue(bit_pkg::OP_BREAKPOINT_INSTR, 4'h1, 4'h0, 32'h0, 32'h0, 32'h502, 1'b0);
      chk_bit("breakpoint halts", 1'b1, s_halt);
      $display("test block done");
   endtask
   task automatic t_exc();
      int n;
      issue(bit_pkg::OP_IT, 4'h0, 4'h0, 32'h0, 32'h10, 32'h600, 1'b0);
      issue(bit_pkg::OP_OTHER, 4'h0, 4'h0, 32'h0, 32'h0, 32'h602, 1'b0);
      s_entry = 1'b0;
      exc <= 1'b1;
      n = 0;
      do begin step(); n++; end while (in_hnd !== 1'b1 && n < 20);
      exc <= 1'b0;
      chk_bit("handler entered", 1'b1, s_entry);
      chk_word("resume address", 32'h604, link_val);
      chk_word("stacked slots", 32'h1, {29'h0, program_status_word[2:0]});
      issue(bit_pkg::OP_ERET, 4'he, 4'h0, 32'h604, {21'h0, program_status_word[10:0]}, 32'h700, 1'b0);
      chk_bit("handler left", 1'b0, in_hnd);
      chk_word("restored slots", 32'h1, {29'h0, lk.it_left});
      chk_word("restored cond", 32'h0, {28'h0, lk.it_cond});
      issue(bit_pkg::OP_OTHER, 4'h0, 4'h0, 32'h0, 32'h0, 32'h604, 1'b0);
      chk_bit("resumed slot runs", 1'b0, s_skip);
      chk_word("block done", 32'h0, {29'h0, lk.it_left});
      $display("test exception done");
   endtask
   initial begin
      int n;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      n = 0;
      do begin step(); n++; end while (ready !== 1'b1 && n < 10);
      flags <= 4'h4;
      flags_we <= 1'b1;
      step();
      flags_we <= 1'b0;
      t_branch();
      t_cmp();
      t_block();
      t_exc();
      print_verdict();
   end
endmodule
